// ---- common/backup_key_defines.vh ----
`ifndef BACKUP_KEY_DEFINES_VH
`define BACKUP_KEY_DEFINES_VH
// ----------------------------------------
// serial register addresses (16-bit halves)
// ----------------------------------------
`define REG_ACCESS_KEY_HI   16'h0040
`define REG_ACCESS_KEY_LO   16'h0041
`define REG_WRITE_KEY_HI    16'h0042
`define REG_WRITE_KEY_LO    16'h0043
`define REG_RESTORE_HI      16'h0196
`define REG_RESTORE_LO      16'h0197
`define REG_STORE_HI        16'h0198
`define REG_STORE_LO        16'h0199
// ----------------------------------------
// network command codes
// ----------------------------------------
`define CMD_ACCESS_KEY_RD   16'h0020
`define CMD_WRITE_KEY_RD    16'h0021
`define CMD_ACCESS_KEY_WR   16'h1020
`define CMD_WRITE_KEY_WR    16'h1021
`define CMD_RESTORE_WR      16'h30cb
`define CMD_STORE_WR        16'h30cc
// ----------------------------------------
// key codes and reset values
// ----------------------------------------
`define ACCESS_KEY_CODE     32'h01391955
`define WRITE_KEY_CODE      32'h75db9c97
`define KEY_RESET           32'h00000000
`endif

// ---- hw/backup_copy_engine.v ----
`timescale 1ns/1ps
`include "backup_key_defines.vh"
// ----------------------------------------
// word-by-word copy between settings and backup
// ----------------------------------------
module backup_copy_engine #(
  parameter WORDS = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          rstn,
  // commands
  input  wire          startStore,
  input  wire          startRestore,
  output wire          busy,
  output reg           doneStore_ff,
  output reg           doneRestore_ff,
  // working settings side
  output reg  [AW-1:0] setAddr_ff,
  input  wire [31:0]   setRdata,
  output reg  [31:0]   setWdata_ff,
  output reg           setWe_ff
);
  // ----------------------------------------
  // one-hot state machine
  // ----------------------------------------
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_STORE = 3'b010;
  localparam [2:0] S_RESTORE = 3'b100;
  reg [2:0]    state_ff;
  reg [AW-1:0] idx_ff;
  reg [31:0]   backupMem [0:WORDS-1];
  wire         lastIdx = (idx_ff == WORDS - 1);
  assign busy = ~state_ff[0];
  always @(posedge clk_sys) begin
    if (state_ff == S_STORE)
      backupMem[idx_ff] <= setRdata;
  end
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff       <= S_IDLE;
      idx_ff         <= {AW{1'b0}};
      setAddr_ff     <= {AW{1'b0}};
      setWdata_ff    <= 32'h00000000;
      setWe_ff       <= 1'b0;
      doneStore_ff   <= 1'b0;
      doneRestore_ff <= 1'b0;
    end else begin
      setWe_ff       <= 1'b0;
      doneStore_ff   <= 1'b0;
      doneRestore_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          idx_ff     <= {AW{1'b0}};
          setAddr_ff <= {AW{1'b0}};
          if (startStore)
            state_ff <= S_STORE;
          else if (startRestore)
            state_ff <= S_RESTORE;
        end
        S_STORE: begin
          idx_ff     <= idx_ff + 1'b1;
          setAddr_ff <= idx_ff + 1'b1;
          if (lastIdx) begin
            state_ff     <= S_IDLE;
            doneStore_ff <= 1'b1;
          end
        end
        S_RESTORE: begin
          setAddr_ff  <= idx_ff;
          setWdata_ff <= backupMem[idx_ff];
          setWe_ff    <= 1'b1;
          idx_ff      <= idx_ff + 1'b1;
          if (lastIdx) begin
            state_ff       <= S_IDLE;
            doneRestore_ff <= 1'b1;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // backup_copy_engine

// ---- hw/keyed_backup_area_control.v ----
// Functional notes
// - access key register, serial and network
// - write key register, reset zero
// - restore trigger copies backup to settings
// - store trigger copies settings to backup
// - store needs both keys matching
// - restore needs access key only
// - serial and network reach the same keys and triggers; a network key write wins over a serial half
`timescale 1ns/1ps
`include "backup_key_defines.vh"
module keyed_backup_area_control #(
  parameter WORDS = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          rstn,
  // serial register port (16-bit halves)
  input  wire          serWe,
  input  wire          serRe,
  input  wire [15:0]   serAddr,
  input  wire [15:0]   serWdata,
  output reg  [15:0]   serRdata_ff,
  output reg           serAck_ff,
  output reg           serErr_ff,
  // network command port (32-bit)
  input  wire          netValid,
  input  wire [15:0]   netCode,
  input  wire [31:0]   netWdata,
  output reg  [31:0]   netRdata_ff,
  output reg           netAck_ff,
  output reg           netErr_ff,
  // working settings store
  output wire [AW-1:0] setAddr,
  input  wire [31:0]   setRdata,
  output wire [31:0]   setWdata,
  output wire          setWe,
  // status
  output wire          busy,
  output wire          storeDone,
  output wire          restoreDone,
  output reg           keyReject_ff
);
  // ----------------------------------------
  // key registers
  // ----------------------------------------
  reg  [31:0] accessKey_ff;
  reg  [31:0] writeKey_ff;
  // ----------------------------------------
  // decode results
  // ----------------------------------------
  reg  [15:0] nxtSerRdata;
  reg         serHit;
  reg         serStore;
  reg         serRestore;
  reg  [31:0] nxtNetRdata;
  reg         netHit;
  reg         netStore;
  reg         netRestore;
  // ----------------------------------------
  // command gating
  // ----------------------------------------
  wire        accessOk = (accessKey_ff == `ACCESS_KEY_CODE);
  wire        writeOk  = (writeKey_ff == `WRITE_KEY_CODE);
  wire        wantStore   = serStore | netStore;
  wire        wantRestore = serRestore | netRestore;
  reg         goStore;
  reg         goRestore;
  reg         cmdDrop;
  // ----------------------------------------
  // serial decode
  // ----------------------------------------
  always @* begin
    nxtSerRdata = 16'h0000;
    serHit      = 1'b1;
    serStore    = 1'b0;
    serRestore  = 1'b0;
    case (serAddr)
      `REG_ACCESS_KEY_HI: nxtSerRdata = accessKey_ff[31:16];
      `REG_ACCESS_KEY_LO: nxtSerRdata = accessKey_ff[15:0];
      `REG_WRITE_KEY_HI:  nxtSerRdata = writeKey_ff[31:16];
      `REG_WRITE_KEY_LO:  nxtSerRdata = writeKey_ff[15:0];
      `REG_RESTORE_HI, `REG_RESTORE_LO: serRestore = serWe;
      `REG_STORE_HI, `REG_STORE_LO:     serStore = serWe;
      default: serHit = 1'b0;
    endcase
  end
  // ----------------------------------------
  // network decode
  // ----------------------------------------
  always @* begin
    nxtNetRdata = 32'h00000000;
    netHit      = netValid;
    netStore    = 1'b0;
    netRestore  = 1'b0;
    case (netCode)
      `CMD_ACCESS_KEY_RD: nxtNetRdata = accessKey_ff;
      `CMD_WRITE_KEY_RD:  nxtNetRdata = writeKey_ff;
      `CMD_ACCESS_KEY_WR: nxtNetRdata = 32'h00000000;
      `CMD_WRITE_KEY_WR:  nxtNetRdata = 32'h00000000;
      `CMD_RESTORE_WR:    netRestore = netValid;
      `CMD_STORE_WR:      netStore = netValid;
      default: netHit = 1'b0;
    endcase
  end
  // ----------------------------------------
  // command arbiter
  // ----------------------------------------
  // store wins when both triggers land together
  always @* begin
    goStore   = 1'b0;
    goRestore = 1'b0;
    if (!busy) begin
      if (wantStore)
        goStore = accessOk & writeOk;
      else if (wantRestore)
        goRestore = accessOk;
    end
    // refused while busy or without keys, never queued
    cmdDrop = (wantStore | wantRestore) & ~goStore & ~goRestore;
  end
  // ----------------------------------------
  // key write strobes
  // ----------------------------------------
  // key halves load independently, in either order
  wire        serReq     = serWe | serRe;
  wire        serWrAccHi = serWe & (serAddr == `REG_ACCESS_KEY_HI);
  wire        serWrAccLo = serWe & (serAddr == `REG_ACCESS_KEY_LO);
  wire        serWrKeyHi = serWe & (serAddr == `REG_WRITE_KEY_HI);
  wire        serWrKeyLo = serWe & (serAddr == `REG_WRITE_KEY_LO);
  wire        netWrAcc   = netValid & (netCode == `CMD_ACCESS_KEY_WR);
  wire        netWrKey   = netValid & (netCode == `CMD_WRITE_KEY_WR);
  // ----------------------------------------
  // access key register
  // ----------------------------------------
  // a whole network key wins over a serial half
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      accessKey_ff <= `KEY_RESET;
    end else if (netWrAcc) begin
      accessKey_ff <= netWdata;
    end else begin
      if (serWrAccHi)
        accessKey_ff[31:16] <= serWdata;
      if (serWrAccLo)
        accessKey_ff[15:0] <= serWdata;
    end
  end
  // ----------------------------------------
  // write key register
  // ----------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      writeKey_ff <= `KEY_RESET;
    end else if (netWrKey) begin
      writeKey_ff <= netWdata;
    end else begin
      if (serWrKeyHi)
        writeKey_ff[31:16] <= serWdata;
      if (serWrKeyLo)
        writeKey_ff[15:0] <= serWdata;
    end
  end
  // ----------------------------------------
  // serial answer
  // ----------------------------------------
  // read data holds until the next read
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serRdata_ff <= 16'h0000;
      serAck_ff   <= 1'b0;
      serErr_ff   <= 1'b0;
    end else begin
      serAck_ff <= serReq;
      serErr_ff <= serReq & ~serHit;
      if (serRe)
        serRdata_ff <= nxtSerRdata;
    end
  end
  // ----------------------------------------
  // network answer
  // ----------------------------------------
  // write and trigger codes answer with zero data
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      netRdata_ff <= 32'h00000000;
      netAck_ff   <= 1'b0;
      netErr_ff   <= 1'b0;
    end else begin
      netAck_ff <= netValid;
      netErr_ff <= netValid & ~netHit;
      if (netValid)
        netRdata_ff <= nxtNetRdata;
    end
  end
  // ----------------------------------------
  // refused command flag
  // ----------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      keyReject_ff <= 1'b0;
    else
      keyReject_ff <= cmdDrop;
  end
  // ----------------------------------------
  // copy engine
  // ----------------------------------------
  backup_copy_engine #(
    .WORDS (WORDS),
    .AW    (AW)
  ) u_copy (
    .clk_sys        (clk_sys),
    .rstn           (rstn),
    .startStore     (goStore),
    .startRestore   (goRestore),
    .busy           (busy),
    .doneStore_ff   (storeDone),
    .doneRestore_ff (restoreDone),
    .setAddr_ff     (setAddr),
    .setRdata       (setRdata),
    .setWdata_ff    (setWdata),
    .setWe_ff       (setWe)
  );
endmodule // keyed_backup_area_control

// ---- sim/keyed_backup_area_control_assertions.sv ----
`timescale 1ns/1ps
`include "backup_key_defines.vh"
module backup_ctl_checker #(
  parameter WORDS = 16
) (
  // clock and reset
  input wire        clk_sys,
  input wire        rstn,
  // serial port
  input wire        serWe,
  input wire        serRe,
  input wire [15:0] serAddr,
  input wire        serAck_ff,
  input wire        serErr_ff,
  // network port
  input wire        netValid,
  input wire [15:0] netCode,
  input wire        netAck_ff,
  input wire        netErr_ff,
  // settings and status
  input wire        setWe,
  input wire        busy,
  input wire        storeDone,
  input wire        restoreDone,
  input wire        keyReject_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  reg  [7:0] busyCnt_ff;
  reg        busyPrev_ff;
  wire       cmd = (serWe && serAddr >= `REG_RESTORE_HI &&
    serAddr <= `REG_STORE_LO) || (netValid &&
    (netCode == `CMD_RESTORE_WR || netCode == `CMD_STORE_WR));
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busyCnt_ff <= 8'h00;
      busyPrev_ff <= 1'b0;
    end else begin
      busyPrev_ff <= busy;
      if (busy)
        busyCnt_ff <= busyPrev_ff ? busyCnt_ff + 8'h01 : 8'h01;
    end
  end
  sequence s_cmdIdle; cmd && !busy; endsequence
  sequence s_outcome; ##1 (busy != keyReject_ff); endsequence
  property p_cmdOutcome; s_cmdIdle |-> s_outcome; endproperty
  property p_busyReject; cmd && busy |=> keyReject_ff; endproperty
  property p_serAck; serWe || serRe |=> serAck_ff; endproperty
  property p_netAck; netValid |=> netAck_ff; endproperty
  property p_serErr; serErr_ff |-> serAck_ff; endproperty
  property p_netErr; netErr_ff |-> netAck_ff; endproperty
  property p_restoreLast; restoreDone |-> setWe; endproperty
  property p_storeNoWe; storeDone |-> !setWe; endproperty
  property p_doneSpan; storeDone || restoreDone |->
    busyCnt_ff >= WORDS - 1 && busyCnt_ff <= WORDS; endproperty
  a_cmdOutcome: assert property (p_cmdOutcome)
    else $error("command outcome wrong");
  a_busyReject: assert property (p_busyReject)
    else $error("busy command not refused");
  a_serAck: assert property (p_serAck) else $error("no serial ack");
  a_netAck: assert property (p_netAck) else $error("no net ack");
  a_serErr: assert property (p_serErr) else $error("serial err");
  a_netErr: assert property (p_netErr) else $error("net err");
  a_restoreLast: assert property (p_restoreLast) else $error("rdone");
  a_storeNoWe: assert property (p_storeNoWe) else $error("sdone");
  a_doneSpan: assert property (p_doneSpan) else $error("copy span");
endmodule // backup_ctl_checker
bind keyed_backup_area_control backup_ctl_checker #(.WORDS(WORDS)) u_chk (
  .clk_sys      (clk_sys),
  .rstn         (rstn),
  .serWe        (serWe),
  .serRe        (serRe),
  .serAddr      (serAddr),
  .serAck_ff    (serAck_ff),
  .serErr_ff    (serErr_ff),
  .netValid     (netValid),
  .netCode      (netCode),
  .netAck_ff    (netAck_ff),
  .netErr_ff    (netErr_ff),
  .setWe        (setWe),
  .busy         (busy),
  .storeDone    (storeDone),
  .restoreDone  (restoreDone),
  .keyReject_ff (keyReject_ff)
);

// ---- sim/settings_store_model.sv ----
`timescale 1ns/1ps
module settings_store_model #(parameter WORDS = 16, parameter AW = 4) (
  // clock
  input  wire          clk_sys,
  // settings port
  input  wire [AW-1:0] setAddr,
  input  wire [31:0]   setWdata,
  input  wire          setWe,
  output wire [31:0]   setRdata
);
  reg [31:0] mem [0:WORDS-1];
  assign setRdata = mem[setAddr];
  always @(posedge clk_sys)
    if (setWe) mem[setAddr] <= setWdata;
endmodule // settings_store_model

// ---- sim/tb_keyed_backup_area_control.sv ----
`timescale 1ns/1ps
`include "backup_key_defines.vh"
module tb_keyed_backup_area_control;
  localparam WORDS = 8;
  localparam AW = 3;
  reg          clk_sys = 1'b0, rstn = 1'b0, serWe = 1'b0, serRe = 1'b0;
  reg          netValid = 1'b0;
  reg [15:0]   serAddr = 16'h0000, serWdata = 16'h0000, netCode = 16'h0000;
  reg [31:0]   netWdata = 32'h00000000;
  reg [31:0]   golden [0:WORDS-1];
  wire [15:0]  serRdata;
  wire [31:0]  netRdata, setRdata, setWdata;
  wire [AW-1:0] setAddr;
  wire         serAck, serErr, netAck, netErr, setWe, busy;
  wire         storeDone, restoreDone, keyRej;
  logic [34:0] q[$];
  logic [34:0] e;
  logic [34:0] got;
  reg   [31:0] rnd;
  integer      seed = 32'hf347c267, mismatches = 0, testsRun = 0, i;
  keyed_backup_area_control #(.WORDS(WORDS), .AW(AW)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .serWe(serWe), .serRe(serRe),
    .serAddr(serAddr), .serWdata(serWdata), .serRdata_ff(serRdata),
    .serAck_ff(serAck), .serErr_ff(serErr), .netValid(netValid),
    .netCode(netCode), .netWdata(netWdata), .netRdata_ff(netRdata),
    .netAck_ff(netAck), .netErr_ff(netErr), .setAddr(setAddr),
    .setRdata(setRdata), .setWdata(setWdata), .setWe(setWe), .busy(busy),
    .storeDone(storeDone), .restoreDone(restoreDone),
    .keyReject_ff(keyRej));
  settings_store_model #(.WORDS(WORDS), .AW(AW)) store (.clk_sys(clk_sys),
    .setAddr(setAddr), .setWdata(setWdata), .setWe(setWe),
    .setRdata(setRdata));
  function [34:0] x(input r, c, er, input [31:0] d);
    x = {r, c, er, d};
  endfunction
  task chkAns(input [34:0] ex, seen);
    testsRun++;
    if (ex !== seen) begin
      mismatches++;
      $display("mismatch answer expected %h seen %h", ex, seen);
    end
  endtask
  task chkWord(input string n, input [31:0] ex, seen);
    testsRun++;
    if (ex !== seen) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, ex, seen);
    end
  endtask
  task chkFlag(input string n, input ex, seen);
    testsRun++;
    if (ex !== seen) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", n, ex, seen);
    end
  endtask
  task ser(input w, input [15:0] a, d, input [34:0] ex);
    @(negedge clk_sys);
    serWe = w;
    serRe = !w;
    serAddr = a;
    serWdata = d;
    q.push_back(ex);
    @(negedge clk_sys);
    serWe = 1'b0;
    serRe = 1'b0;
  endtask
  task net(input [15:0] c, input [31:0] d, input [34:0] ex);
    @(negedge clk_sys);
    netValid = 1'b1;
    netCode = c;
    netWdata = d;
    q.push_back(ex);
    @(negedge clk_sys);
    netValid = 1'b0;
  endtask
  task memChk(input string n);
    for (i = 0; i < WORDS; i++) chkWord(n, golden[i], store.mem[i]);
  endtask
  task waitDone(input s, input integer expBusy);
    integer n;
    n = 0;
    for (i = 0; i < 100 && (s ? storeDone : restoreDone) !== 1'b1; i++) begin
      if (busy === 1'b1)
        n++;
      @(negedge clk_sys);
    end
    chkFlag("done", 1'b1, i < 100);
    chkWord("busy cycles", expBusy, n);
    @(negedge clk_sys);
  endtask
  task printVerdict;
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(negedge clk_sys) begin
    if (serAck | netAck) begin
      e = q.pop_front();
      got = {keyRej, e[33], serAck ? serErr : netErr,
        e[33] ? (serAck ? {16'h0000, serRdata} : netRdata) : e[31:0]};
      chkAns(e, got);
    end
  end
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    printVerdict;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1'b1;
    ser(0, `REG_ACCESS_KEY_LO, 16'h0000, x(0, 1, 0, 0));
    net(`CMD_WRITE_KEY_RD, 0, x(0, 1, 0, 0));
    ser(0, 16'h0050, 16'h0000, x(0, 1, 1, 0));
    net(16'h1234, 0, x(0, 1, 1, 0));
    for (i = 0; i < WORDS; i++) begin
      golden[i] = $random(seed);
      store.mem[i] = golden[i];
    end
    ser(1, `REG_RESTORE_LO, 16'h0000, x(1, 0, 0, 0));
    ser(1, `REG_ACCESS_KEY_HI, 16'h0139, x(0, 0, 0, 0));
    ser(1, `REG_ACCESS_KEY_LO, 16'h1955, x(0, 0, 0, 0));
    net(`CMD_STORE_WR, 0, x(1, 1, 0, 0));
    memChk("held");
    net(`CMD_WRITE_KEY_WR, `WRITE_KEY_CODE, x(0, 1, 0, 0));
    ser(0, `REG_WRITE_KEY_HI, 16'h0000, x(0, 1, 0, 32'h75db));
    net(`CMD_ACCESS_KEY_RD, 0, x(0, 1, 0, `ACCESS_KEY_CODE));
    ser(1, `REG_STORE_HI, 16'h0000, x(0, 0, 0, 0));
    waitDone(1, WORDS);
    for (i = 0; i < WORDS; i++) store.mem[i] = ~golden[i];
    rnd = $random(seed);
    net(`CMD_WRITE_KEY_WR, rnd, x(0, 1, 0, 0));
    ser(1, `REG_WRITE_KEY_LO, ~rnd[15:0], x(0, 0, 0, 0));
    net(`CMD_WRITE_KEY_RD, 0, x(0, 1, 0, {rnd[31:16], ~rnd[15:0]}));
    net(`CMD_ACCESS_KEY_WR, `ACCESS_KEY_CODE, x(0, 1, 0, 0));
    ser(0, `REG_RESTORE_HI, 16'h0000, x(0, 1, 0, 0));
    net(`CMD_RESTORE_WR, 0, x(0, 1, 0, 0));
    ser(1, `REG_RESTORE_HI, 16'h0000, x(1, 0, 0, 0));
    waitDone(0, WORDS - 2);
    memChk("restored");
    printVerdict;
  end
endmodule // tb_keyed_backup_area_control
